// ---- hw/fdso_pkg.sv ----
// fdso package: register map, field layout and divider constants
// What this block does
// - A first divider write with the load-control bit at 0 locks the register until reset.
// - A divider write with the load-control bit at 1 keeps the register open for the next write.
// - Bit 7 of the divider register reads 0 until it is written after reset, then 1.
// - Prescale bit 6 at 1 divides the bus clock by 8 before the divider, at 0 feeds it directly.
// - The timing clock is the bus clock over divide field plus one (over 2 for field 0 unprescaled), times 8 when prescaled.
// - The overall division ratio stays between 2 and 512.
// - The security option register reads fully and ignores every write.
// - The security option register is loaded from the nonvolatile security byte at reset.
// - Backdoor key access is enabled only when bits 7:6 hold 10.
// - The device is unsecured when bits 1:0 hold 10 or after a backdoor unlock, secured otherwise.
// - After a successful backdoor unlock the security field reads as unsecured.
// - The key write access bit is writable only while backdoor access is enabled.
package fdso_pkg;
  // ****************************************
  // bus and register map
  // ****************************************
  localparam int APB_ADDR_W = 8;
  localparam int APB_DATA_W = 32;
  localparam int REG_W = 8;
  localparam logic [7:0] OFF_TIMING_DIV = 8'h00;
  localparam logic [7:0] OFF_SEC_OPT = 8'h04;
  localparam logic [7:0] OFF_KEY_CFG = 8'h08;
  localparam int WORD_LSB = 2;
  // ****************************************
  // field layout
  // ****************************************
  localparam int LOADED_BIT = 7;
  localparam int PRESCALE_BIT = 6;
  localparam int DIV_W = 6;
  localparam int DIV_MSB = 5;
  localparam int KEY_EN_MSB = 7;
  localparam int KEY_EN_LSB = 6;
  localparam int SEC_MSB = 1;
  localparam int SEC_LSB = 0;
  localparam int KEY_ACC_BIT = 5;
  localparam logic [1:0] KEY_EN_ENABLED = 2'h2;
  localparam logic [1:0] SEC_UNSECURED = 2'h2;
  // ****************************************
  // divider
  // ****************************************
  localparam int PRE_W = 3;
  localparam int RATIO_W = 10;
  localparam logic [RATIO_W-1:0] RATIO_MIN = 10'h002;
  localparam logic [RATIO_W-1:0] RATIO_MAX = 10'h200;
endpackage

// ---- hw/fdso_clkdiv.sv ----
// fdso timing clock divider: optional prescale then programmable divide
`timescale 1ns/100ps
`default_nettype none
module fdso_clkdiv #(
  parameter int DIV_W = fdso_pkg::DIV_W,
  parameter int PRE_W = fdso_pkg::PRE_W
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // configuration
  input wire logic en_in,
  input wire logic prescale_in,
  input wire logic [DIV_W-1:0] div_in,
  // timing clock strobe
  output logic tick_out
);
  typedef struct packed {
    logic [DIV_W:0] cfg;
    logic [PRE_W-1:0] pre;
    logic [DIV_W-1:0] cnt;
    logic tick;
  } fdso_div_s;

  fdso_div_s st;
  fdso_div_s next_st;
  logic [DIV_W:0] cfg;
  logic [DIV_W-1:0] div_eff;
  logic restart;

  assign cfg = {prescale_in, div_in};
  assign div_eff = (!prescale_in && div_in == '0) ? DIV_W'(1) : div_in;
  assign restart = !en_in || cfg != st.cfg;
  assign tick_out = st.tick;

  always_comb
  begin
    next_st = st;
    next_st.tick = 1'b0;
    if (restart)
    begin
      next_st.cfg = cfg;
      next_st.pre = '0;
      next_st.cnt = '0;
    end
    else
    begin
      if (prescale_in)
        next_st.pre = st.pre + 1'b1;
      if (!prescale_in || st.pre == '1)
      begin
        if (st.cnt == div_eff)
        begin
          next_st.cnt = '0;
          next_st.tick = 1'b1;
        end
        else
          next_st.cnt = st.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      st <= '0;
    else
      st <= next_st;
  end

  // ****************************************
  // checks
  // ****************************************
  logic [fdso_pkg::RATIO_W-1:0] ratio;
  logic [fdso_pkg::RATIO_W-1:0] gap;
  logic fresh;

  assign ratio = fdso_pkg::RATIO_W'({1'b0, div_eff} + 1'b1) << (prescale_in ? PRE_W : 0);

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      gap <= '0;
      fresh <= 1'b1;
    end
    else
    begin
      gap <= st.tick ? '0 : gap + 1'b1;
      fresh <= restart || (fresh && !st.tick);
    end
  end

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  property p_ratio_range;
    ratio >= fdso_pkg::RATIO_MIN && ratio <= fdso_pkg::RATIO_MAX;
  endproperty
  a_ratio_range: assert property (p_ratio_range) else $error("divide ratio out of range");

  property p_tick_spacing;
    st.tick && !fresh && !restart |-> gap == ratio - 1'b1;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("timing tick spacing wrong");

  property p_prescale_phase;
    st.tick && prescale_in && $stable(prescale_in) |-> $past(st.pre) == '1;
  endproperty
  a_prescale_phase: assert property (p_prescale_phase) else $error("prescaled tick off phase");
endmodule
`default_nettype wire

// ---- hw/fdso_top.sv ----
// fdso top: timing divider, security option and key access registers on apb
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module fdso_top (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // apb slave
  input wire logic [fdso_pkg::APB_ADDR_W-1:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [fdso_pkg::APB_DATA_W-1:0] pwdata_in,
  output logic pready_out,
  output logic [fdso_pkg::APB_DATA_W-1:0] prdata_out,
  output logic pslverr_out,
  // nonvolatile byte and unlock status
  input wire logic [fdso_pkg::REG_W-1:0] nonvolatile_security_byte_in,
  input wire logic backdoor_unlocked_in,
  // block status
  output logic flash_timing_clock_out,
  output logic divider_loaded_flag_out,
  output logic backdoor_key_enabled_out,
  output logic secured_out,
  output logic key_write_access_out
);
  typedef struct packed {
    logic nv_loaded;
    logic written;
    logic locked;
    logic prescale;
    logic [fdso_pkg::DIV_W-1:0] div;
    logic [fdso_pkg::REG_W-1:0] opt;
    logic key_acc;
    logic key_en;
    logic secured;
    logic pready;
    logic pslverr;
    logic [fdso_pkg::APB_DATA_W-1:0] prdata;
  } fdso_regs_s;

  fdso_regs_s st;
  fdso_regs_s next_st;

  // ****************************************
  // address decode
  // ****************************************
  logic sel_div;
  logic sel_opt;
  logic sel_key;
  logic hit;
  logic start;
  logic done;
  logic wr_done;

  assign sel_div = paddr_in[fdso_pkg::APB_ADDR_W-1:fdso_pkg::WORD_LSB]
                   == fdso_pkg::OFF_TIMING_DIV[fdso_pkg::APB_ADDR_W-1:fdso_pkg::WORD_LSB];
  assign sel_opt = paddr_in[fdso_pkg::APB_ADDR_W-1:fdso_pkg::WORD_LSB]
                   == fdso_pkg::OFF_SEC_OPT[fdso_pkg::APB_ADDR_W-1:fdso_pkg::WORD_LSB];
  assign sel_key = paddr_in[fdso_pkg::APB_ADDR_W-1:fdso_pkg::WORD_LSB]
                   == fdso_pkg::OFF_KEY_CFG[fdso_pkg::APB_ADDR_W-1:fdso_pkg::WORD_LSB];
  assign hit = sel_div || sel_opt || sel_key;
  assign start = psel_in && penable_in && !st.pready && st.nv_loaded;
  assign done = psel_in && penable_in && st.pready;
  assign wr_done = done && pwrite_in;

  // ****************************************
  // read values
  // ****************************************
  logic [1:0] sec_rd;
  logic key_enabled;
  logic [fdso_pkg::REG_W-1:0] div_rd;
  logic [fdso_pkg::REG_W-1:0] opt_rd;
  logic [fdso_pkg::REG_W-1:0] key_rd;
  logic [fdso_pkg::REG_W-1:0] rdata;

  assign sec_rd = backdoor_unlocked_in ? fdso_pkg::SEC_UNSECURED
                                       : st.opt[fdso_pkg::SEC_MSB:fdso_pkg::SEC_LSB];
  assign key_enabled = st.opt[fdso_pkg::KEY_EN_MSB:fdso_pkg::KEY_EN_LSB]
                       == fdso_pkg::KEY_EN_ENABLED;
  assign div_rd = {st.written, st.prescale, st.div};
  assign opt_rd = {st.opt[fdso_pkg::REG_W-1:fdso_pkg::SEC_MSB+1], sec_rd};
  assign key_rd = fdso_pkg::REG_W'(st.key_acc) << fdso_pkg::KEY_ACC_BIT;
  assign rdata = sel_div ? div_rd : sel_opt ? opt_rd : sel_key ? key_rd : '0;

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    next_st = st;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    if (!st.nv_loaded)
    begin
      next_st.opt = nonvolatile_security_byte_in;
      next_st.nv_loaded = 1'b1;
    end
    // one wait state answer
    if (start)
    begin
      next_st.pready = 1'b1;
      next_st.pslverr = !hit;
      next_st.prdata = pwrite_in ? '0 : fdso_pkg::APB_DATA_W'(rdata);
    end
    if (wr_done && sel_div && !st.locked)
    begin
      next_st.written = 1'b1;
      next_st.locked = !pwdata_in[fdso_pkg::LOADED_BIT];
      next_st.prescale = pwdata_in[fdso_pkg::PRESCALE_BIT];
      next_st.div = pwdata_in[fdso_pkg::DIV_MSB:0];
    end
    if (wr_done && sel_key && key_enabled)
      next_st.key_acc = pwdata_in[fdso_pkg::KEY_ACC_BIT];
    next_st.key_en = key_enabled;
    next_st.secured = sec_rd != fdso_pkg::SEC_UNSECURED;
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      st <= '0;
    else
      st <= next_st;
  end

  // ****************************************
  // timing clock divider
  // ****************************************
  logic tick;

  fdso_clkdiv #(
    .DIV_W(fdso_pkg::DIV_W),
    .PRE_W(fdso_pkg::PRE_W)
  ) u_clkdiv (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .en_in(st.written),
    .prescale_in(st.prescale),
    .div_in(st.div),
    .tick_out(tick)
  );

  // ****************************************
  // outputs
  // ****************************************
  assign pready_out = st.pready;
  assign prdata_out = st.prdata;
  assign pslverr_out = st.pslverr;
  assign flash_timing_clock_out = tick;
  assign divider_loaded_flag_out = st.written;
  assign backdoor_key_enabled_out = st.key_en;
  assign secured_out = st.secured;
  assign key_write_access_out = st.key_acc;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  property p_lock_holds;
    wr_done && sel_div && st.locked |=> $stable(div_rd);
  endproperty
  a_lock_holds: assert property (p_lock_holds) else $error("locked divider changed");

  property p_first_zero_locks;
    wr_done && sel_div && !st.locked && !pwdata_in[fdso_pkg::LOADED_BIT] |=> st.locked;
  endproperty
  a_first_zero_locks: assert property (p_first_zero_locks) else $error("divider not locked");

  property p_one_keeps_open;
    wr_done && sel_div && !st.locked && pwdata_in[fdso_pkg::LOADED_BIT] |=> !st.locked;
  endproperty
  a_one_keeps_open: assert property (p_one_keeps_open) else $error("divider locked by one");

  property p_loaded_read;
    done && !pwrite_in && sel_div |-> prdata_out[fdso_pkg::LOADED_BIT] == st.written;
  endproperty
  a_loaded_read: assert property (p_loaded_read) else $error("loaded flag read wrong");

  property p_div_update;
    wr_done && sel_div && !st.locked
      |=> st.div == $past(pwdata_in[fdso_pkg::DIV_MSB:0])
          && st.prescale == $past(pwdata_in[fdso_pkg::PRESCALE_BIT]);
  endproperty
  a_div_update: assert property (p_div_update) else $error("divider fields not updated");

  property p_opt_readonly;
    st.nv_loaded && wr_done && sel_opt |=> $stable(st.opt);
  endproperty
  a_opt_readonly: assert property (p_opt_readonly) else $error("option register written");

  property p_nv_load;
    !st.nv_loaded |=> st.nv_loaded && st.opt == $past(nonvolatile_security_byte_in);
  endproperty
  a_nv_load: assert property (p_nv_load) else $error("security byte not loaded");

  property p_key_enable;
    st.nv_loaded ##1 1'b1 |-> backdoor_key_enabled_out
      == ($past(st.opt[fdso_pkg::KEY_EN_MSB:fdso_pkg::KEY_EN_LSB]) == fdso_pkg::KEY_EN_ENABLED);
  endproperty
  a_key_enable: assert property (p_key_enable) else $error("key enable decode wrong");

  property p_secured;
    st.nv_loaded && !backdoor_unlocked_in
      |=> secured_out == ($past(st.opt[fdso_pkg::SEC_MSB:fdso_pkg::SEC_LSB])
                          != fdso_pkg::SEC_UNSECURED);
  endproperty
  a_secured: assert property (p_secured) else $error("security decode wrong");

  property p_unlock_read;
    start && !pwrite_in && sel_opt && backdoor_unlocked_in
      |=> prdata_out[fdso_pkg::SEC_MSB:fdso_pkg::SEC_LSB] == fdso_pkg::SEC_UNSECURED
          && !secured_out;
  endproperty
  a_unlock_read: assert property (p_unlock_read) else $error("unlock not forced");

  property p_key_gate;
    wr_done && sel_key && !key_enabled |=> $stable(st.key_acc);
  endproperty
  a_key_gate: assert property (p_key_gate) else $error("key access written while disabled");

  property p_answer_time;
    start |=> pready_out ##1 !pready_out;
  endproperty
  a_answer_time: assert property (p_answer_time) else $error("apb answer timing wrong");

  property p_err_unmapped;
    start && !hit |=> pslverr_out && prdata_out == '0;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");

  property p_err_mapped;
    start && hit |=> !pslverr_out;
  endproperty
  a_err_mapped: assert property (p_err_mapped) else $error("mapped access refused");

  property p_write_data_zero;
    start && pwrite_in |=> prdata_out == '0;
  endproperty
  a_write_data_zero: assert property (p_write_data_zero) else $error("write answer carries data");

  property p_upper_zero;
    pready_out |-> prdata_out[fdso_pkg::APB_DATA_W-1:fdso_pkg::REG_W] == '0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero");

  property p_ready_pulse;
    pready_out |=> !pready_out;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

  property p_ready_cause;
    pready_out |-> $past(psel_in) && $past(penable_in);
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("ready without access");

  property p_written_sticky;
    st.written |=> st.written;
  endproperty
  a_written_sticky: assert property (p_written_sticky) else $error("loaded flag dropped");

  property p_written_cause;
    !st.written && !(wr_done && sel_div) |=> !st.written;
  endproperty
  a_written_cause: assert property (p_written_cause) else $error("flag set without write");

  property p_locked_sticky;
    st.locked |=> st.locked;
  endproperty
  a_locked_sticky: assert property (p_locked_sticky) else $error("divider lock dropped");

  property p_div_read;
    start && !pwrite_in && sel_div
      |=> prdata_out[fdso_pkg::DIV_MSB:0] == $past(st.div)
          && prdata_out[fdso_pkg::PRESCALE_BIT] == $past(st.prescale);
  endproperty
  a_div_read: assert property (p_div_read) else $error("divider read wrong");

  property p_opt_read;
    start && !pwrite_in && sel_opt && !backdoor_unlocked_in
      |=> prdata_out[fdso_pkg::REG_W-1:0] == $past(st.opt);
  endproperty
  a_opt_read: assert property (p_opt_read) else $error("option read wrong");

  property p_opt_frozen;
    st.nv_loaded |=> $stable(st.opt);
  endproperty
  a_opt_frozen: assert property (p_opt_frozen) else $error("option changed after load");

  property p_key_read;
    start && !pwrite_in && sel_key
      |=> prdata_out[fdso_pkg::KEY_ACC_BIT] == $past(st.key_acc);
  endproperty
  a_key_read: assert property (p_key_read) else $error("key access read wrong");

  property p_key_write;
    wr_done && sel_key && key_enabled
      |=> st.key_acc == $past(pwdata_in[fdso_pkg::KEY_ACC_BIT]);
  endproperty
  a_key_write: assert property (p_key_write) else $error("key access not written");

  property p_tick_idle;
    !st.written |=> !flash_timing_clock_out;
  endproperty
  a_tick_idle: assert property (p_tick_idle) else $error("timing strobe before write");
endmodule
`default_nettype wire

// ---- bench/fdso_top_tb.sv ----
// fdso top testbench: apb register access, lock, security decode and timing strobe
`timescale 1ns/100ps
`default_nettype none
module fdso_top_tb;
  // ****************************************
  // signals and instance
  // ****************************************
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] paddr_in = 8'h00;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [31:0] pwdata_in = 32'h0;
  logic [7:0] nv_byte = 8'h00;
  logic unlocked = 1'b0;
  logic pready_out;
  logic [31:0] prdata_out;
  logic pslverr_out;
  logic tick;
  logic loaded;
  logic key_en;
  logic secured;
  logic key_acc;
  int fails = 0;
  int n_tests = 0;
  int cycles = 0;
  fdso_top u_fdso_top (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .paddr_in(paddr_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .pwdata_in(pwdata_in),
    .pready_out(pready_out), .prdata_out(prdata_out), .pslverr_out(pslverr_out),
    .nonvolatile_security_byte_in(nv_byte), .backdoor_unlocked_in(unlocked),
    .flash_timing_clock_out(tick), .divider_loaded_flag_out(loaded),
    .backdoor_key_enabled_out(key_en), .secured_out(secured), .key_write_access_out(key_acc)
  );
  always #2.5 ref_clk_in = ~ref_clk_in;
  // ****************************************
  // helpers
  // ****************************************
  task automatic tally_and_finish();
    $display("tests %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge ref_clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      fails = fails + 1;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge ref_clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    paddr_in <= a;
    pwrite_in <= w;
    pwdata_in <= {24'h0, d};
    @(posedge ref_clk_in);
    penable_in <= 1'b1;
    @(posedge ref_clk_in);
    while (pready_out !== 1'b1)
      @(posedge ref_clk_in);
    r = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    chk(r, {24'h0, exp});
  endtask
  task automatic do_reset(input logic [7:0] b);
    @(posedge ref_clk_in);
    rst_in <= 1'b1;
    nv_byte <= b;
    repeat (3) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
  endtask
  task automatic period(output int n);
    n = 0;
    @(negedge ref_clk_in);
    while (tick !== 1'b1)
      @(negedge ref_clk_in);
    @(negedge ref_clk_in);
    n = 1;
    while (tick !== 1'b1)
    begin
      @(negedge ref_clk_in);
      n = n + 1;
    end
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_codes();
    logic [7:0] dv [4] = '{8'h00, 8'h81, 8'hC0, 8'hFF}; // no program or erase follows
    int ratio [4] = '{2, 2, 8, 512};
    logic [1:0] k;
    int n;
    for (int i = 0; i < 4; i++)
    begin
      k = i[1:0];
      do_reset({k, 4'h9, k});
      rd_chk(8'h00, 8'h00);
      chk(loaded, 1'b0);
      rd_chk(8'h04, {k, 4'h9, k});
      chk(key_en, k == 2'b10);
      chk(secured, k != 2'b10);
      wr(8'h08, 8'h20);
      rd_chk(8'h08, (k == 2'b10) ? 8'h20 : 8'h00);
      chk(key_acc, k == 2'b10);
      wr(8'h00, dv[i]);
      @(negedge ref_clk_in);
      chk(loaded, 1'b1);
      rd_chk(8'h00, dv[i] | 8'h80);
      period(n);
      chk(n, ratio[i]);
      wr(8'h00, 8'hBF);
      rd_chk(8'h00, (i == 0) ? 8'h80 : 8'hBF);
    end
  endtask
  task automatic t_lock();
    logic [31:0] r;
    logic e;
    int n;
    wr(8'h00, 8'h43);
    rd_chk(8'h00, 8'hC3);
    period(n);
    chk(n, 32);
    wr(8'h00, 8'h01);
    rd_chk(8'h00, 8'hC3);
    period(n);
    chk(n, 32);
    wr(8'h04, 8'h5A);
    rd_chk(8'h04, 8'hE7);
    apb(1'b0, 8'h0C, 8'h00, r, e);
    chk(e, 1'b1);
  endtask
  task automatic t_unlock();
    unlocked <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    chk(secured, 1'b0);
    rd_chk(8'h04, 8'hE6);
  endtask
  initial
  begin
    t_codes();
    t_lock();
    t_unlock();
    tally_and_finish();
  end
endmodule
`default_nettype wire
